/* core/scs_pkg.sv */
package scs_pkg;

  // Bus and data widths
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CMD_W = 17;
  localparam int unsigned REF_W = 16;
  localparam int unsigned SCALE_W = 16;
  localparam int unsigned REF_FRAC = 15;

  // Register byte offsets
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_PRESET_FIRST = 5'h04;
  localparam logic [4:0] OFS_PRESET_SECOND = 5'h08;
  localparam logic [4:0] OFS_PRESET_THIRD = 5'h0C;
  localparam logic [4:0] OFS_SCALE = 5'h10;
  localparam logic [4:0] OFS_STATUS = 5'h14;
  localparam logic [4:0] OFS_SPEED_CMD = 5'h18;
  localparam logic [4:0] OFS_SPEED_LIMIT = 5'h1C;

  // Field positions
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_MANUAL_BIT = 2;
  localparam int unsigned STATUS_SRC_LSB = 0;
  localparam int unsigned STATUS_ARMED_BIT = 2;
  localparam int unsigned STATUS_MODE_LSB = 4;
  localparam int unsigned STATUS_MANUAL_BIT = 6;

  // Preset limits in 0.1 r/min counts, reset values
  localparam logic signed [16:0] PRESET_MAX = 17'sh0EA60;
  localparam logic signed [16:0] PRESET_MIN = 17'sh115A0;
  localparam logic [16:0] PRESET_RST = 17'h00000;
  localparam logic [15:0] SCALE_RST = 16'h7530;
  localparam logic CTRL_MANUAL_RST = 1'b0;

  typedef enum logic [1:0] {
    MODE_SPEED = 2'b00,
    MODE_SPEED_ZERO = 2'b01,
    MODE_TORQUE = 2'b10,
    MODE_TORQUE_ZERO = 2'b11
  } scs_mode_e;

  typedef enum logic [1:0] {
    SOURCE_ANALOG_OR_ZERO = 2'b00,
    SOURCE_PRESET_FIRST = 2'b01,
    SOURCE_PRESET_SECOND = 2'b10,
    SOURCE_PRESET_THIRD = 2'b11
  } scs_src_e;

  // Saturate a wide signed value into the legal command span
  function automatic logic [16:0] scs_clamp(input logic signed [31:0] v);
    if (v > 32'(PRESET_MAX)) begin
      return PRESET_MAX;
    end else if (v < 32'(PRESET_MIN)) begin
      return PRESET_MIN;
    end
    return v[16:0];
  endfunction

  // Sign-extend a command word to the bus width
  function automatic logic [31:0] scs_sext(input logic [16:0] v);
    return {{15{v[16]}}, v};
  endfunction

endpackage

/* core/scs_analog_scale.sv */
`timescale 1ns/100ps
`default_nettype none

module scs_analog_scale (
  input wire logic ref_clk_i, // Core clock
  input wire logic rst_i, // Async reset, high
  input wire logic [15:0] analog_ref_i, // Signed converter code
  input wire logic [15:0] scale_i, // Full-scale speed, 0.1 r/min
  output logic [16:0] scaled_o // Scaled, saturated command
);

  typedef struct packed {
    logic [16:0] scaled;
  } scs_analog_s;

  scs_analog_s st;
  scs_analog_s next_st;
  logic signed [32:0] prod;
  logic signed [31:0] shifted;

  // Full-scale code maps to the programmed speed; saturate to the legal span
  always_comb begin
    prod = $signed(analog_ref_i) * $signed({1'b0, scale_i}); // [RULE_08]
    shifted = 32'(prod >>> scs_pkg::REF_FRAC);
    next_st = st;
    next_st.scaled = scs_pkg::scs_clamp(shifted); // [RULE_01]
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign scaled_o = st.scaled;

  a_zero_input: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE_08]
    analog_ref_i == 16'h0000 |=> scaled_o == 17'h00000)
    else $error("zero reference did not give zero speed");
  a_sign_follow: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE_08]
    !analog_ref_i[15] |=> !scaled_o[16])
    else $error("positive reference gave negative speed");

endmodule

`default_nettype wire

/* core/scs_avalon_slave.sv */
`timescale 1ns/100ps
`default_nettype none

module scs_avalon_slave (
  input wire logic ref_clk_i, // Core clock
  input wire logic rst_i, // Async reset, high
  input wire logic avs_read_i, // Avalon read
  input wire logic avs_write_i, // Avalon write
  input wire logic [31:0] rd_data_i, // Read mux from register file
  output logic avs_waitrequest_o, // Avalon waitrequest
  output logic [31:0] avs_readdata_o, // Avalon read data
  output logic wr_en_o // Write takes effect this edge
);

  typedef struct packed {
    logic waitrequest;
    logic [31:0] rdata;
  } scs_slave_s;

  scs_slave_s st;
  scs_slave_s next_st;

  // One wait cycle per access; waitrequest rises again right after the answer
  always_comb begin
    next_st = st;
    next_st.waitrequest = !((avs_read_i || avs_write_i) && st.waitrequest);
    if (avs_read_i && st.waitrequest) begin
      next_st.rdata = rd_data_i;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '{waitrequest: 1'b1, rdata: 32'h00000000};
    end else begin
      st <= next_st;
    end
  end

  assign avs_waitrequest_o = st.waitrequest;
  assign avs_readdata_o = st.rdata;
  assign wr_en_o = avs_write_i && !st.waitrequest;

  a_wait_release: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("access not answered after one wait cycle");
  a_wait_return: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");

endmodule

`default_nettype wire

/* core/scs_top.sv */
// Summary of operation
// RULE_01: Selects 00, analog mode: analog reference drives command.
// RULE_02: Selects 00, zero mode: command forced zero.
// RULE_03: Nonzero selects pick first, second, third preset.
// RULE_04: Select input OFF decodes 0, ON 1.
// RULE_05: Preset applies only after a select change.
// RULE_06: Presets saturate to plus/minus 60000 counts.
// RULE_07: Torque modes use command as speed limit.
// RULE_08: Analog full scale maps to programmable speed.
// RULE_09: Serial writes may change preset values.
// RULE_10: Manual tuning disables automatic and auxiliary gains.
// RULE_11: Command output is registered, one clean update.
//
// The Avalon-MM interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module scs_top (
  input wire logic ref_clk_i, // 25 MHz core clock
  input wire logic rst_i, // Async reset, high
  input wire logic [4:0] avs_address_i, // Avalon byte address
  input wire logic avs_read_i, // Avalon read
  input wire logic avs_write_i, // Avalon write
  input wire logic [31:0] avs_writedata_i, // Avalon write data
  output logic [31:0] avs_readdata_o, // Avalon read data
  output logic avs_waitrequest_o, // Avalon waitrequest
  input wire logic speed_select_low_i, // Select pin, low bit, ON high
  input wire logic speed_select_high_i, // Select pin, high bit, ON high
  input wire logic [15:0] analog_ref_i, // Converter code, same clock
  output logic [16:0] speed_cmd_o, // Speed setpoint, 0.1 r/min
  output logic [16:0] speed_limit_o, // Torque-mode speed limit
  output logic cmd_update_o, // Pulse when command changes
  output logic auto_tune_en_o, // Automatic gain tuning allowed
  output logic aux_gain_en_o, // Auxiliary gain functions allowed
  output logic [1:0] active_source_o // Source in use
);

  typedef struct packed {
    logic [1:0] sel_meta;
    logic [1:0] sel_sync;
    logic [1:0] sel_prev;
    logic [2:0] sync_fill;
    logic armed;
    scs_pkg::scs_mode_e mode;
    logic manual;
    logic [2:0][16:0] preset;
    logic [15:0] scale;
    logic [16:0] speed_cmd;
    logic [16:0] speed_limit;
    logic cmd_update;
    logic auto_tune_en;
    logic aux_gain_en;
    scs_pkg::scs_src_e src;
  } scs_state_s;

  scs_state_s st;
  scs_state_s next_st;
  logic wr_en;
  logic [31:0] rd_data;
  logic [16:0] analog_cmd;
  logic [16:0] sel_cmd;
  logic [16:0] preset_sel;
  logic torque_mode;
  logic zero_mode;

  // Preset for a nonzero select pattern; 00 owns no preset and reads as zero
  // A case keeps the lookup inside the bank instead of indexing past its end
  function automatic logic [16:0] pick_preset(input logic [1:0] pat, input logic [2:0][16:0] bank);
    logic [16:0] v;
    unique case (pat)
      2'b00: begin
        v = 17'h00000;
      end
      2'b01: begin
        v = bank[0];
      end
      2'b10: begin
        v = bank[1];
      end
      2'b11: begin
        v = bank[2];
      end
    endcase
    return v;
  endfunction

  // Bus front end: one wait cycle, writes land on the answering edge
  scs_avalon_slave u_slave (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i),
    .rd_data_i(rd_data),
    .avs_waitrequest_o(avs_waitrequest_o),
    .avs_readdata_o(avs_readdata_o),
    .wr_en_o(wr_en)
  );

  // Analog path; registered, so analog changes reach the output two edges on
  scs_analog_scale u_analog (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .analog_ref_i(analog_ref_i),
    .scale_i(st.scale),
    .scaled_o(analog_cmd)
  );

  // Mode decoding shared by the command path and the checks
  assign torque_mode = st.mode[1];
  assign zero_mode = st.mode[0];
  assign preset_sel = pick_preset(st.sel_sync, st.preset); // [RULE_03]

  // Whole next-state: pin sync, register writes, source choice, outputs
  always_comb begin
    next_st = st;
    sel_cmd = 17'h00000;
    rd_data = 32'h00000000;

    // Pins are asynchronous; the first stage feeds only the second
    next_st.sel_meta = {speed_select_high_i, speed_select_low_i}; // [RULE_04]
    next_st.sel_sync = st.sel_meta;
    next_st.sel_prev = st.sel_sync;

    // Compare only real pin samples; the step from the reset pattern to the
    // pins as they stand is not an operator move and must not arm presets
    next_st.sync_fill = {st.sync_fill[1:0], 1'b1};

    // A preset is not trusted until the operator moves a select input
    if (st.sync_fill[2] && st.sel_sync != st.sel_prev) begin
      next_st.armed = 1'b1; // [RULE_05]
    end

    // Register writes; unmapped offsets are ignored
    if (wr_en) begin
      unique case (avs_address_i)
        scs_pkg::OFS_CTRL: begin
          next_st.mode = scs_pkg::scs_mode_e'(avs_writedata_i[scs_pkg::CTRL_MODE_LSB +: 2]);
          next_st.manual = avs_writedata_i[scs_pkg::CTRL_MANUAL_BIT];
        end
        scs_pkg::OFS_PRESET_FIRST: begin
          next_st.preset[0] = scs_pkg::scs_clamp(avs_writedata_i); // [RULE_06] [RULE_09]
        end
        scs_pkg::OFS_PRESET_SECOND: begin
          next_st.preset[1] = scs_pkg::scs_clamp(avs_writedata_i); // [RULE_06] [RULE_09]
        end
        scs_pkg::OFS_PRESET_THIRD: begin
          next_st.preset[2] = scs_pkg::scs_clamp(avs_writedata_i); // [RULE_06] [RULE_09]
        end
        scs_pkg::OFS_SCALE: begin
          next_st.scale = avs_writedata_i[15:0]; // [RULE_08]
        end
        default: begin
        end
      endcase
    end

    // Read mux; status and live command are read-only
    unique case (avs_address_i)
      scs_pkg::OFS_CTRL: begin
        rd_data[scs_pkg::CTRL_MODE_LSB +: 2] = st.mode;
        rd_data[scs_pkg::CTRL_MANUAL_BIT] = st.manual;
      end
      scs_pkg::OFS_PRESET_FIRST: begin
        rd_data = scs_pkg::scs_sext(st.preset[0]);
      end
      scs_pkg::OFS_PRESET_SECOND: begin
        rd_data = scs_pkg::scs_sext(st.preset[1]);
      end
      scs_pkg::OFS_PRESET_THIRD: begin
        rd_data = scs_pkg::scs_sext(st.preset[2]);
      end
      scs_pkg::OFS_SCALE: begin
        rd_data[15:0] = st.scale;
      end
      scs_pkg::OFS_STATUS: begin
        rd_data[scs_pkg::STATUS_SRC_LSB +: 2] = st.src;
        rd_data[scs_pkg::STATUS_ARMED_BIT] = st.armed;
        rd_data[scs_pkg::STATUS_MODE_LSB +: 2] = st.mode;
        rd_data[scs_pkg::STATUS_MANUAL_BIT] = st.manual;
      end
      scs_pkg::OFS_SPEED_CMD: begin
        rd_data = scs_pkg::scs_sext(st.speed_cmd);
      end
      scs_pkg::OFS_SPEED_LIMIT: begin
        rd_data = scs_pkg::scs_sext(st.speed_limit);
      end
      default: begin
      end
    endcase

    // Source choice from the synchronised select pattern
    next_st.src = scs_pkg::scs_src_e'(st.sel_sync); // [RULE_03]
    if (st.sel_sync == 2'b00) begin
      if (zero_mode) begin
        sel_cmd = 17'h00000; // [RULE_02]
      end else begin
        sel_cmd = analog_cmd; // [RULE_01]
      end
    end else if (st.armed) begin
      sel_cmd = preset_sel; // [RULE_03]
    end else begin
      sel_cmd = 17'h00000; // [RULE_05]
    end

    // Torque modes reuse the command as a limit and drop the setpoint
    if (torque_mode) begin
      next_st.speed_cmd = 17'h00000; // [RULE_07]
      next_st.speed_limit = sel_cmd; // [RULE_07]
    end else begin
      next_st.speed_cmd = sel_cmd;
      next_st.speed_limit = 17'h00000;
    end

    // Single pulse per change so downstream ramps see one clean step
    next_st.cmd_update = (next_st.speed_cmd != st.speed_cmd) ||
                         (next_st.speed_limit != st.speed_limit); // [RULE_11]

    // Manual tuning leaves only the user loop gains in force
    next_st.auto_tune_en = !st.manual; // [RULE_10]
    next_st.aux_gain_en = !st.manual; // [RULE_10]
  end

  // Single register bank for all state
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '{
        sel_meta: 2'h0,
        sel_sync: 2'h0,
        sel_prev: 2'h0,
        sync_fill: 3'h0,
        armed: 1'b0,
        mode: scs_pkg::MODE_SPEED,
        manual: scs_pkg::CTRL_MANUAL_RST,
        preset: {3{scs_pkg::PRESET_RST}},
        scale: scs_pkg::SCALE_RST,
        speed_cmd: 17'h00000,
        speed_limit: 17'h00000,
        cmd_update: 1'b0,
        auto_tune_en: 1'b0,
        aux_gain_en: 1'b0,
        src: scs_pkg::SOURCE_ANALOG_OR_ZERO
      };
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign speed_cmd_o = st.speed_cmd;
  assign speed_limit_o = st.speed_limit;
  assign cmd_update_o = st.cmd_update;
  assign auto_tune_en_o = st.auto_tune_en;
  assign aux_gain_en_o = st.aux_gain_en;
  assign active_source_o = st.src;

  // Checks on the command path
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  a_analog_source: assert property ( // [RULE_01]
    st.sel_sync == 2'b00 && st.mode == scs_pkg::MODE_SPEED
    |=> speed_cmd_o == $past(analog_cmd))
    else $error("analog reference not used as command");

  a_zero_force: assert property ( // [RULE_02]
    st.sel_sync == 2'b00 && st.mode == scs_pkg::MODE_SPEED_ZERO
    |=> speed_cmd_o == 17'h00000 && speed_limit_o == 17'h00000)
    else $error("zero mode did not force zero command");

  a_preset_pick: assert property ( // [RULE_03]
    st.armed && st.sel_sync == 2'b10 && !torque_mode
    |=> speed_cmd_o == $past(st.preset[1]) && active_source_o == 2'b10)
    else $error("select 10 did not pick second preset");

  a_pin_decode: assert property ( // [RULE_04]
    st.sync_fill[1]
    |-> st.sel_sync == {$past(speed_select_high_i, 2), $past(speed_select_low_i, 2)})
    else $error("select pins decoded wrongly");

  a_unarmed_hold: assert property ( // [RULE_05]
    !st.armed && st.sel_sync != 2'b00
    |=> speed_cmd_o == 17'h00000 && speed_limit_o == 17'h00000)
    else $error("preset applied before any select change");

  // Arming and the remaining preset slots
  a_arm_guard: assert property ( // [RULE_05]
    $rose(st.armed)
    |-> $past(st.sel_sync) != $past(st.sel_prev) && $past(st.sync_fill[2]))
    else $error("presets armed without a select change");

  a_preset_first: assert property ( // [RULE_03]
    st.armed && st.sel_sync == 2'b01 && !torque_mode
    |=> speed_cmd_o == $past(st.preset[0]) && active_source_o == 2'b01)
    else $error("select 01 did not pick first preset");

  a_preset_third: assert property ( // [RULE_03]
    st.armed && st.sel_sync == 2'b11 && !torque_mode
    |=> speed_cmd_o == $past(st.preset[2]) && active_source_o == 2'b11)
    else $error("select 11 did not pick third preset");

  a_torque_preset: assert property ( // [RULE_07]
    st.armed && st.sel_sync == 2'b11 && torque_mode
    |=> speed_limit_o == $past(st.preset[2]) && speed_cmd_o == 17'h00000)
    else $error("torque mode did not limit with third preset");

  a_limit_idle: assert property ( // [RULE_07]
    !torque_mode
    |=> speed_limit_o == 17'h00000)
    else $error("speed limit driven outside torque modes");

  a_preset_range: assert property ( // [RULE_06]
    $signed(st.preset[0]) <= scs_pkg::PRESET_MAX &&
    $signed(st.preset[0]) >= scs_pkg::PRESET_MIN &&
    $signed(st.preset[2]) <= scs_pkg::PRESET_MAX &&
    $signed(st.preset[2]) >= scs_pkg::PRESET_MIN)
    else $error("preset outside legal span");

  a_torque_limit: assert property ( // [RULE_07]
    torque_mode |=> speed_cmd_o == 17'h00000 && speed_limit_o == $past(sel_cmd))
    else $error("torque mode did not route command to limit");

  a_preset_write: assert property ( // [RULE_09]
    wr_en && avs_address_i == scs_pkg::OFS_PRESET_FIRST
    |=> st.preset[0] == scs_pkg::scs_clamp($past(avs_writedata_i)))
    else $error("preset write not stored");

  a_manual_gain: assert property ( // [RULE_10]
    st.manual ##1 st.manual |-> !auto_tune_en_o && !aux_gain_en_o)
    else $error("manual tuning left automatic gains on");

  a_update_pulse: assert property ( // [RULE_11]
    ($changed(speed_cmd_o) || $changed(speed_limit_o)) == cmd_update_o)
    else $error("update pulse not tied to command change");

  c_analog_run: cover property (
    st.mode == scs_pkg::MODE_SPEED && st.sel_sync == 2'b00 ##1 cmd_update_o);
  c_preset_third: cover property (
    st.armed && st.sel_sync == 2'b11 ##1 cmd_update_o);
  c_torque_limit: cover property (
    torque_mode && speed_limit_o != 17'h00000);
  c_manual_mode: cover property (
    st.manual && !auto_tune_en_o);
  c_arm_event: cover property (
    $rose(st.armed));

endmodule

`default_nettype wire

/* verification/scs_host_model.sv */
`timescale 1ns/100ps
`default_nettype none

module scs_host_model (
  input wire logic ref_clk_i, // Core clock
  output logic speed_select_low_o, // Select low bit, ON drives 1
  output logic speed_select_high_o, // Select high bit, ON drives 1
  output logic [15:0] analog_ref_o // Signed reference code
);
  // Pattern 01 stands through reset so the first preset is selected but not yet applied
  initial begin
    speed_select_low_o = 1'b1;
    speed_select_high_o = 1'b0;
    analog_ref_o = 16'h0000;
  end

  // Pins move just after an edge; the idle cycles mimic a slow controller
  task automatic set_sel(input logic [1:0] pat, input int dly);
    repeat (dly + 1) @(posedge ref_clk_i);
    {speed_select_high_o, speed_select_low_o} <= pat;
  endtask

  // The converter code is held until the next call
  task automatic set_ref(input logic [15:0] code);
    @(posedge ref_clk_i);
    analog_ref_o <= code;
  endtask
endmodule

`default_nettype wire

/* verification/tb.sv */
`timescale 1ns/100ps
`default_nettype none

module tb;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [4:0] avs_address_i = 5'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h00000000;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic sel_low;
  logic sel_high;
  logic [15:0] analog_ref;
  logic [16:0] speed_cmd_o;
  logic [16:0] speed_limit_o;
  logic cmd_update_o;
  logic auto_tune_en_o;
  logic aux_gain_en_o;
  logic [1:0] active_source_o;
  int fail_count = 0;
  int num_checks = 0;
  int seed = 32'h49ea;
  logic [35:0] exp_q[$];
  logic [35:0] e_now;
  logic [31:0] rdat;
  logic [15:0] code;
  logic [15:0] scale;
  logic [16:0] last;
  logic [1:0] cur_sel;

  always #20 ref_clk_i = ~ref_clk_i;

  scs_host_model host (
    .ref_clk_i(ref_clk_i),
    .speed_select_low_o(sel_low),
    .speed_select_high_o(sel_high),
    .analog_ref_o(analog_ref)
  );

  scs_top dut (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .speed_select_low_i(sel_low),
    .speed_select_high_i(sel_high),
    .analog_ref_i(analog_ref),
    .speed_cmd_o(speed_cmd_o),
    .speed_limit_o(speed_limit_o),
    .cmd_update_o(cmd_update_o),
    .auto_tune_en_o(auto_tune_en_o),
    .aux_gain_en_o(aux_gain_en_o),
    .active_source_o(active_source_o)
  );

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Scaled analog speed, own arithmetic so a shared slip cannot hide
  function automatic logic [16:0] ana(input logic [15:0] c, input logic [15:0] s);
    logic signed [40:0] p;
    p = ($signed({{25{c[15]}}, c}) * $signed({25'h0000000, s})) >>> 15;
    if (p > 41'sd60000) return 17'h0EA60;
    if (p < -41'sd60000) return 17'h115A0;
    return p[16:0];
  endfunction

  // One bus cycle: request held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_read_i <= ~w;
    avs_write_i <= w;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    rdat = avs_readdata_o;
    if (n >= 50) check("waitrequest", 32'h0, 32'h1);
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] exp, input string name);
    bus(1'b0, a, 32'h00000000);
    check(name, exp, rdat);
  endtask

  // Each expected update is noted before its cause is driven
  task automatic expect_cmd(input logic [16:0] c, input logic [16:0] l);
    exp_q.push_back({c, l, cur_sel});
  endtask

  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 200) begin
      @(posedge ref_clk_i);
      n++;
    end
    if (exp_q.size() != 0) check("missing update", 32'h0, 32'(exp_q.size()));
    repeat (8) @(posedge ref_clk_i);
  endtask

  task automatic sel(input logic [1:0] p, input logic [16:0] c);
    cur_sel = p;
    expect_cmd(c, 17'h00000);
    host.set_sel(p, $unsigned($random(seed)) % 4);
    drain();
  endtask

  task automatic ref_step(input logic [15:0] c);
    last = ana(c, scale);
    if (last !== ana(analog_ref, scale)) expect_cmd(last, 17'h00000);
    host.set_ref(c);
    drain();
  endtask

  // Every pulse must match the oldest note; a pulse with none noted is spurious
  always @(posedge ref_clk_i) begin
    if (rst_i === 1'b0 && cmd_update_o === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("spurious cmd_update_o", 32'h0, 32'h1);
      end else begin
        e_now = exp_q.pop_front();
        check("speed_cmd_o", 32'(e_now[35:19]), 32'(speed_cmd_o));
        check("speed_limit_o", 32'(e_now[18:2]), 32'(speed_limit_o));
        check("active_source_o", 32'(e_now[1:0]), 32'(active_source_o));
      end
    end
  end

  // Watchdog sized well past the few hundred cycles the sequence needs
  initial begin
    #1000000;
    fail_count++;
    finish_test();
  end

  initial begin
    cur_sel = 2'b01;
    scale = 16'h7530;
    repeat (4) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    check("auto_tune_en_o", 32'h1, 32'(auto_tune_en_o));
    check("aux_gain_en_o", 32'h1, 32'(aux_gain_en_o));
    rd(scs_pkg::OFS_CTRL, 32'h00000000, "ctrl reset");
    rd(scs_pkg::OFS_SCALE, 32'h00007530, "scale reset");
    rd(scs_pkg::OFS_PRESET_FIRST, 32'h00000000, "preset reset");
    rd(5'h01, 32'h00000000, "unmapped read");
    rd(scs_pkg::OFS_STATUS, 32'h00000001, "status unarmed");
    bus(1'b1, scs_pkg::OFS_PRESET_FIRST, 32'h000004D2);
    bus(1'b1, scs_pkg::OFS_PRESET_SECOND, 32'hFFFF15A0);
    bus(1'b1, scs_pkg::OFS_PRESET_THIRD, 32'h00011170);
    bus(1'b1, scs_pkg::OFS_STATUS, 32'h000000FF);
    rd(scs_pkg::OFS_PRESET_SECOND, 32'hFFFF15A0, "preset min");
    rd(scs_pkg::OFS_PRESET_THIRD, 32'h0000EA60, "preset saturated");
    rd(scs_pkg::OFS_STATUS, 32'h00000001, "status read-only");
    repeat (8) @(posedge ref_clk_i);
    rd(scs_pkg::OFS_SPEED_CMD, 32'h00000000, "preset held off");
    sel(2'b10, 17'h115A0);
    rd(scs_pkg::OFS_STATUS, 32'h00000006, "status armed");
    sel(2'b11, 17'h0EA60);
    sel(2'b01, 17'h004D2);
    expect_cmd(17'h1FFFB, 17'h00000);
    bus(1'b1, scs_pkg::OFS_PRESET_FIRST, 32'hFFFFFFFB);
    drain();
    rd(scs_pkg::OFS_SPEED_CMD, 32'hFFFFFFFB, "speed_cmd reg");
    expect_cmd(17'h00000, 17'h1FFFB);
    bus(1'b1, scs_pkg::OFS_CTRL, 32'h00000002);
    drain();
    rd(scs_pkg::OFS_SPEED_LIMIT, 32'hFFFFFFFB, "speed_limit reg");
    cur_sel = 2'b11;
    expect_cmd(17'h00000, 17'h0EA60);
    host.set_sel(2'b11, 0);
    drain();
    expect_cmd(17'h0EA60, 17'h00000);
    bus(1'b1, scs_pkg::OFS_CTRL, 32'h00000000);
    drain();
    sel(2'b00, 17'h00000);
    ref_step(16'h4000);
    expect_cmd(ana(16'h4000, 16'h4E20), 17'h00000);
    scale = 16'h4E20;
    bus(1'b1, scs_pkg::OFS_SCALE, 32'h00004E20);
    drain();
    ref_step(16'h8000);
    for (int i = 0; i < 6; i++) begin
      code = 16'($random(seed));
      ref_step(code);
    end
    ref_step(16'h2000);
    expect_cmd(17'h00000, 17'h00000);
    bus(1'b1, scs_pkg::OFS_CTRL, 32'h00000001);
    drain();
    host.set_ref(16'h7FFF);
    repeat (8) @(posedge ref_clk_i);
    expect_cmd(ana(16'h7FFF, scale), 17'h00000);
    bus(1'b1, scs_pkg::OFS_CTRL, 32'h00000000);
    drain();
    expect_cmd(17'h00000, 17'h00000);
    bus(1'b1, scs_pkg::OFS_CTRL, 32'h00000003);
    drain();
    expect_cmd(ana(16'h7FFF, scale), 17'h00000);
    bus(1'b1, scs_pkg::OFS_CTRL, 32'h00000004);
    drain();
    check("auto_tune_en_o", 32'h0, 32'(auto_tune_en_o));
    check("aux_gain_en_o", 32'h0, 32'(aux_gain_en_o));
    rd(scs_pkg::OFS_STATUS, 32'h00000044, "status manual");
    finish_test();
  end
endmodule

`default_nettype wire
